// >>> fvrp_ctrl.sv
// Purpose: verify, one-time read and program-phrase command sequencer with apb registers
// Assumes: one array operation per req/ack; array ack is a one-cycle pulse
// Notes:   zero-wait apb, read data captured in setup phase
// Function
// - block verify 0x02 takes block bits [17:16] from slot 0, verifies whole block
// - completion flag low while operation runs, set when it ends
// - block verify launched with slot index not 000 raises access error
// - block verify with invalid block bits [17:16] raises access error
// - verify reads set verify error on any error, uncorrectable on hard error
// - section verify 0x03: block slot 000, address slot 001, count slot 010
// - section verify launched with slot index not 010 raises access error
// - section verify and program with address [2:0] nonzero raise access error
// - section crossing a 128 Kbyte boundary raises access error
// - section verify and program outside program memory raise access error
// - section, one-time read, program unavailable in locked mode raise access error
// - one-time read 0x04 accepts phrase index 0 to 7 in slot 001
// - one-time read puts four words in slots 010 to 101, then completes
// - one-time read launched with slot index not 001 raises access error
// - one-time read with index out of range raises access error
// - ordinary reads of program flash during one-time read return invalid
// - program 0x06 takes address from slots 0,1, data 2 to 5, then reads back
// - program launched with slot index not 101 raises access error
// - program to a protected address raises protection violation
// - program read-back sets verify error on error or mismatch, uncorrectable on hard error
// - command with access error at launch is not processed
// - read of busy block is invalid and sets both fault flags if none set
`timescale 1ns/1ns
`include "fvrp_map.svh"
module fvrp_ctrl #(
    parameter int unsigned BLOCK_PHRASES = 16384
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    output fvrp_pkg::fvrp_arr_req_type      arr_req,
    input  wire fvrp_pkg::fvrp_arr_rsp_type arr_rsp,
    input  wire logic                       host_rd_valid,
    input  wire logic [17:0]                host_rd_addr,
    output logic                            host_rd_invalid
);
    import fvrp_pkg::*;

    fvrp_state_type state;
    logic           command_complete_flag;
    logic           access_error_flag;
    logic           protection_violation_flag;
    logic           verify_error_status;
    logic           uncorrectable_error_status;
    logic           single_fault_detect_flag;
    logic           double_fault_detect_flag;
    logic [2:0]     parameter_slot_index;
    logic [15:0]    command_parameter_array [0:5];
    logic           mode_lock;
    logic           prot_en;
    logic [17:0]    prot_start;
    logic [17:0]    run_addr;
    logic [15:0]    remaining;
    logic [31:0]    rd_word;
    logic           apb_setup;
    logic           apb_write;
    logic           launch;
    logic           running;
    logic [7:0]     cmd;
    logic [17:0]    full_addr;
    logic           chk_acc;
    logic           chk_prot;
    logic           ev_verify;
    logic           ev_uncorr;
    logic           busy_block_read;
    logic [63:0]    prog_word;

    function automatic logic is_mapped(input logic [7:0] a);
        return a == `FVRP_OFF_STAT || a == `FVRP_OFF_INDEX || a == `FVRP_OFF_PARAM ||
               a == `FVRP_OFF_CFG || a == `FVRP_OFF_PROT || a == `FVRP_OFF_FAULT;
    endfunction

    function automatic logic in_pflash(input logic [17:0] a);
        return a <= `FVRP_PFLASH_LAST;
    endfunction

    function automatic logic section_crosses(input logic [17:0] a, input logic [15:0] cnt);
        logic [19:0] span_end;
        span_end = {3'b000, a[16:0]} + {1'b0, cnt, 3'b000};
        return span_end > `FVRP_SECTION_LIMIT;
    endfunction

    // apb slave, zero wait states
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;
    assign pready    = 1'b1;
    assign running   = state == ST_READ || state == ST_PROG || state == ST_VERIFY;
    assign cmd       = command_parameter_array[0][15:8];
    assign full_addr = {command_parameter_array[0][1:0], command_parameter_array[1]};
    assign prog_word = {command_parameter_array[5], command_parameter_array[4],
                        command_parameter_array[3], command_parameter_array[2]};
    // launch refused while old error flags stand
    assign launch    = apb_write && paddr == `FVRP_OFF_STAT && pwdata[`FVRP_STAT_CCF] &&
                       command_complete_flag && !access_error_flag && !protection_violation_flag;

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            `FVRP_OFF_STAT: begin
                rd_word[`FVRP_STAT_CCF] = command_complete_flag;
                rd_word[`FVRP_STAT_ACC] = access_error_flag;
                rd_word[`FVRP_STAT_PV]  = protection_violation_flag;
                rd_word[`FVRP_STAT_VE]  = verify_error_status;
                rd_word[`FVRP_STAT_UE]  = uncorrectable_error_status;
            end
            `FVRP_OFF_INDEX: rd_word[2:0] = parameter_slot_index;
            `FVRP_OFF_PARAM: begin
                if (parameter_slot_index <= `FVRP_SLOT_LAST) begin
                    rd_word[15:0] = command_parameter_array[parameter_slot_index];
                end
            end
            `FVRP_OFF_CFG: rd_word[`FVRP_CFG_LOCK] = mode_lock;
            `FVRP_OFF_PROT: begin
                rd_word[`FVRP_PROT_EN] = prot_en;
                rd_word[17:0]          = prot_start;
            end
            `FVRP_OFF_FAULT: begin
                rd_word[`FVRP_FAULT_DFD] = double_fault_detect_flag;
                rd_word[`FVRP_FAULT_SFD] = single_fault_detect_flag;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr <= !is_mapped(paddr);
        end
    end

    // launch-time checks
    always_comb begin
        chk_prot = 1'b0;
        case (cmd)
            `FVRP_CMD_VERIFY_BLOCK:
                chk_acc = parameter_slot_index != `FVRP_SLOT_CMD ||
                          command_parameter_array[0][1:0] > `FVRP_BLOCK_LAST;
            `FVRP_CMD_VERIFY_SECT:
                chk_acc = parameter_slot_index != `FVRP_SLOT_COUNT || mode_lock ||
                          !in_pflash(full_addr) || full_addr[2:0] != 3'b000 ||
                          section_crosses(full_addr, command_parameter_array[2]);
            `FVRP_CMD_READ_ONCE:
                chk_acc = parameter_slot_index != `FVRP_SLOT_ADDR || mode_lock ||
                          command_parameter_array[1] > `FVRP_ONCE_LAST;
            `FVRP_CMD_PROGRAM: begin
                chk_acc  = parameter_slot_index != `FVRP_SLOT_LAST || mode_lock ||
                           !in_pflash(full_addr) || full_addr[2:0] != 3'b000;
                chk_prot = prot_en && full_addr >= prot_start;
            end
            default: chk_acc = 1'b1;
        endcase
    end

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_IDLE;
            run_addr  <= 18'h00000;
            remaining <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: if (launch) begin
                    state <= ST_CHECK;
                end
                ST_CHECK: begin
                    if (chk_acc || chk_prot) begin
                        state <= ST_DONE;
                    end else if (cmd == `FVRP_CMD_VERIFY_BLOCK) begin
                        run_addr  <= {command_parameter_array[0][1:0], 16'h0000};
                        remaining <= 16'(BLOCK_PHRASES);
                        state     <= ST_READ;
                    end else if (cmd == `FVRP_CMD_VERIFY_SECT) begin
                        run_addr  <= full_addr;
                        remaining <= command_parameter_array[2];
                        state     <= command_parameter_array[2] == 16'h0000 ? ST_DONE : ST_READ;
                    end else if (cmd == `FVRP_CMD_READ_ONCE) begin
                        run_addr <= {12'h000, command_parameter_array[1][2:0], 3'b000};
                        state    <= ST_READ;
                    end else begin
                        run_addr <= full_addr;
                        state    <= ST_PROG;
                    end
                end
                ST_READ: if (arr_rsp.ack) begin
                    if (cmd == `FVRP_CMD_READ_ONCE || remaining == 16'h0001) begin
                        state <= ST_DONE;
                    end else begin
                        remaining <= remaining - 16'h0001;
                        run_addr  <= run_addr + `FVRP_PHRASE_STEP;
                    end
                end
                ST_PROG: if (arr_rsp.ack) begin
                    state <= ST_VERIFY;
                end
                ST_VERIFY: if (arr_rsp.ack) begin
                    state <= ST_DONE;
                end
                ST_DONE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_comb begin
        arr_req.req   = running;
        arr_req.op    = state == ST_PROG ? OP_PROG : (cmd == `FVRP_CMD_READ_ONCE ? OP_READ_INFO : OP_READ);
        arr_req.addr  = run_addr;
        arr_req.wdata = prog_word;
    end

    // read error events during verify reads
    assign ev_verify = arr_rsp.ack && ((state == ST_READ && (arr_rsp.err ||
                       (cmd != `FVRP_CMD_READ_ONCE && arr_rsp.rdata != `FVRP_ERASED))) ||
                       (state == ST_VERIFY && (arr_rsp.err || arr_rsp.rdata != prog_word)));
    assign ev_uncorr = arr_rsp.ack && arr_rsp.uncorr && (state == ST_READ || state == ST_VERIFY);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_complete_flag <= 1'b1;
        end else if (launch) begin
            command_complete_flag <= 1'b0;
        end else if (state == ST_DONE) begin
            command_complete_flag <= 1'b1;
        end
    end

    // sticky error flags, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_error_flag         <= 1'b0;
            protection_violation_flag <= 1'b0;
        end else begin
            if (state == ST_CHECK && chk_acc) begin
                access_error_flag <= 1'b1;
            end else if (apb_write && paddr == `FVRP_OFF_STAT && pwdata[`FVRP_STAT_ACC]) begin
                access_error_flag <= 1'b0;
            end
            if (state == ST_CHECK && chk_prot) begin
                protection_violation_flag <= 1'b1;
            end else if (apb_write && paddr == `FVRP_OFF_STAT && pwdata[`FVRP_STAT_PV]) begin
                protection_violation_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            verify_error_status        <= 1'b0;
            uncorrectable_error_status <= 1'b0;
        end else if (launch) begin
            verify_error_status        <= 1'b0;
            uncorrectable_error_status <= 1'b0;
        end else begin
            if (ev_verify) begin
                verify_error_status <= 1'b1;
            end
            if (ev_uncorr) begin
                uncorrectable_error_status <= 1'b1;
            end
        end
    end

    // slot index and parameter slots, writable only while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parameter_slot_index <= `FVRP_RST_SLOT_INDEX;
            for (int i = 0; i < 6; i++) begin
                command_parameter_array[i] <= `FVRP_RST_PARAM;
            end
        end else if (state == ST_READ && arr_rsp.ack && cmd == `FVRP_CMD_READ_ONCE) begin
            command_parameter_array[2] <= arr_rsp.rdata[15:0];
            command_parameter_array[3] <= arr_rsp.rdata[31:16];
            command_parameter_array[4] <= arr_rsp.rdata[47:32];
            command_parameter_array[5] <= arr_rsp.rdata[63:48];
        end else if (apb_write && command_complete_flag) begin
            if (paddr == `FVRP_OFF_INDEX) begin
                parameter_slot_index <= pwdata[2:0];
            end
            if (paddr == `FVRP_OFF_PARAM && parameter_slot_index <= `FVRP_SLOT_LAST) begin
                command_parameter_array[parameter_slot_index] <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_lock  <= 1'b0;
            prot_en    <= 1'b0;
            prot_start <= `FVRP_RST_PROT_START;
        end else if (apb_write && command_complete_flag) begin
            if (paddr == `FVRP_OFF_CFG) begin
                mode_lock <= pwdata[`FVRP_CFG_LOCK];
            end
            if (paddr == `FVRP_OFF_PROT) begin
                prot_en    <= pwdata[`FVRP_PROT_EN];
                prot_start <= pwdata[17:0];
            end
        end
    end

    // ordinary reads of the block under an algorithm
    // one-time read blocks every program flash address, not only its own block
    assign busy_block_read = host_rd_valid && running && (host_rd_addr[17:16] == run_addr[17:16] ||
                             (cmd == `FVRP_CMD_READ_ONCE && in_pflash(host_rd_addr)));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_rd_invalid          <= 1'b0;
            single_fault_detect_flag <= 1'b0;
            double_fault_detect_flag <= 1'b0;
        end else begin
            host_rd_invalid <= busy_block_read;
            if (busy_block_read && !single_fault_detect_flag && !double_fault_detect_flag) begin
                single_fault_detect_flag <= 1'b1;
                double_fault_detect_flag <= 1'b1;
            end else if (apb_write && paddr == `FVRP_OFF_FAULT) begin
                if (pwdata[`FVRP_FAULT_SFD]) begin
                    single_fault_detect_flag <= 1'b0;
                end
                if (pwdata[`FVRP_FAULT_DFD]) begin
                    double_fault_detect_flag <= 1'b0;
                end
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_check_fail;
        state == ST_CHECK && (chk_acc || chk_prot);
    endsequence
    sequence s_skip_done;
        state == ST_DONE && !arr_req.req ##1 command_complete_flag && state == ST_IDLE;
    endsequence

    property p_busy_flag_low;
        running || state == ST_CHECK |-> !command_complete_flag;
    endproperty
    a_busy_flag_low: assert property (p_busy_flag_low) else $error("completion flag high while busy");

    property p_skip;
        s_check_fail |=> s_skip_done;
    endproperty
    a_skip: assert property (p_skip) else $error("launch error did not skip the array");

    property p_block_index;
        state == ST_CHECK && cmd == `FVRP_CMD_VERIFY_BLOCK && parameter_slot_index != 3'h0 |=> access_error_flag;
    endproperty
    a_block_index: assert property (p_block_index) else $error("block verify index not flagged");

    property p_block_start;
        state == ST_CHECK && !chk_acc && cmd == `FVRP_CMD_VERIFY_BLOCK
            |=> arr_req.req && arr_req.addr == {command_parameter_array[0][1:0], 16'h0000};
    endproperty
    a_block_start: assert property (p_block_start) else $error("block verify start address wrong");

    property p_sect_index;
        state == ST_CHECK && cmd == `FVRP_CMD_VERIFY_SECT && parameter_slot_index != 3'h2 |=> access_error_flag;
    endproperty
    a_sect_index: assert property (p_sect_index) else $error("section index not flagged");

    property p_misalign;
        state == ST_CHECK && (cmd == `FVRP_CMD_VERIFY_SECT || cmd == `FVRP_CMD_PROGRAM) &&
            full_addr[2:0] != 3'b000 |=> access_error_flag ##1 state == ST_IDLE;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned address not flagged");

    property p_once_range;
        state == ST_CHECK && cmd == `FVRP_CMD_READ_ONCE && command_parameter_array[1] > 16'h0007
            |=> access_error_flag && !arr_req.req;
    endproperty
    a_once_range: assert property (p_once_range) else $error("read once index not flagged");

    property p_once_store;
        state == ST_READ && arr_rsp.ack && cmd == `FVRP_CMD_READ_ONCE
            |=> command_parameter_array[5] == $past(arr_rsp.rdata[63:48]) ##1 command_complete_flag;
    endproperty
    a_once_store: assert property (p_once_store) else $error("read once data not stored");

    property p_prog_index;
        state == ST_CHECK && cmd == `FVRP_CMD_PROGRAM && parameter_slot_index != 3'h5 |=> access_error_flag;
    endproperty
    a_prog_index: assert property (p_prog_index) else $error("program index not flagged");

    property p_protect;
        state == ST_CHECK && cmd == `FVRP_CMD_PROGRAM && prot_en && full_addr >= prot_start
            |=> protection_violation_flag && state == ST_DONE;
    endproperty
    a_protect: assert property (p_protect) else $error("protected program not flagged");

    property p_readback;
        state == ST_VERIFY && arr_rsp.ack && arr_rsp.rdata != prog_word |=> verify_error_status;
    endproperty
    a_readback: assert property (p_readback) else $error("read-back mismatch not flagged");

    property p_busy_read;
        busy_block_read && !single_fault_detect_flag && !double_fault_detect_flag
            |=> host_rd_invalid && single_fault_detect_flag && double_fault_detect_flag;
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy block read not flagged");

endmodule // fvrp_ctrl

// >>> fvrp_map.svh
// Purpose: register offsets, field positions, reset values and codes of the flash command sequencer
// Assumes: included by bare name from the design file
// Notes:   definitions only
`ifndef FVRP_MAP_SVH
`define FVRP_MAP_SVH

`define FVRP_OFF_STAT          8'h00
`define FVRP_OFF_INDEX         8'h04
`define FVRP_OFF_PARAM         8'h08
`define FVRP_OFF_CFG           8'h0c
`define FVRP_OFF_PROT          8'h10
`define FVRP_OFF_FAULT         8'h14

`define FVRP_STAT_CCF          7
`define FVRP_STAT_ACC          5
`define FVRP_STAT_PV           4
`define FVRP_STAT_VE           1
`define FVRP_STAT_UE           0
`define FVRP_CFG_LOCK          0
`define FVRP_PROT_EN           31
`define FVRP_FAULT_DFD         1
`define FVRP_FAULT_SFD         0

`define FVRP_CMD_VERIFY_BLOCK  8'h02
`define FVRP_CMD_VERIFY_SECT   8'h03
`define FVRP_CMD_READ_ONCE     8'h04
`define FVRP_CMD_PROGRAM       8'h06

`define FVRP_SLOT_CMD          3'h0
`define FVRP_SLOT_ADDR         3'h1
`define FVRP_SLOT_COUNT        3'h2
`define FVRP_SLOT_LAST         3'h5
`define FVRP_ONCE_LAST         16'h0007
`define FVRP_BLOCK_LAST        2'h1
`define FVRP_PFLASH_LAST       18'h1ffff
`define FVRP_SECTION_LIMIT     20'h20000
`define FVRP_PHRASE_STEP       18'h00008
`define FVRP_ERASED            64'hffff_ffff_ffff_ffff

`define FVRP_RST_SLOT_INDEX    3'h0
`define FVRP_RST_PARAM         16'h0000
`define FVRP_RST_PROT_START    18'h00000

`endif

// >>> fvrp_pkg.sv
// Purpose: types of the flash command sequencer
// Assumes: nothing
// Notes:   array request and answer travel as packed structs
package fvrp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CHECK  = 3'b001,
        ST_READ   = 3'b010,
        ST_PROG   = 3'b011,
        ST_VERIFY = 3'b100,
        ST_DONE   = 3'b101
    } fvrp_state_type;

    typedef enum logic [1:0] {
        OP_READ      = 2'b00,
        OP_READ_INFO = 2'b01,
        OP_PROG      = 2'b10
    } fvrp_op_type;

    typedef struct packed {
        logic        req;
        fvrp_op_type op;
        logic [17:0] addr;
        logic [63:0] wdata;
    } fvrp_arr_req_type;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic        uncorr;
        logic [63:0] rdata;
    } fvrp_arr_rsp_type;

endpackage

// >>> fvrp_array_model.sv
// Purpose: flash array model answering read, info read and program
// Assumes: one request per ack, random latency of one to four cycles
// Notes:   keeps only the last programmed phrase; data toggles outside ack
`timescale 1ns/1ns
module fvrp_array_model (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire fvrp_pkg::fvrp_arr_req_type req,
    input  wire logic                       fail,
    output fvrp_pkg::fvrp_arr_rsp_type      rsp
);
    import fvrp_pkg::*;
    logic [1:0]  cnt;
    logic [17:0] pa;
    logic [63:0] pd;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp <= '0;
            cnt <= 2'h0;
            pa  <= 18'h3ffff;
            pd  <= 64'h0;
        end else begin
            rsp.ack   <= 1'b0;
            rsp.rdata <= ~rsp.rdata;
            if (req.req && !rsp.ack && cnt != 2'h0) cnt <= cnt - 2'h1;
            if (req.req && !rsp.ack && cnt == 2'h0) begin
                rsp <= {1'b1, fail, fail, req.op == OP_READ_INFO ? 64'h4444_3333_2222_1111 :
                        req.addr == pa ? pd : 64'hffff_ffff_ffff_ffff};
                cnt <= 2'($urandom_range(3, 0));
                if (req.op == OP_PROG) begin
                    pa <= req.addr;
                    pd <= req.wdata;
                end
            end
        end
    end
endmodule // fvrp_array_model

// >>> fvrp_ctrl_test.sv
// Purpose: self-checking bench of the flash command sequencer
// Assumes: apb master with one idle cycle between transfers
// Notes:   read results checked against a note queue
`timescale 1ns/1ns
`include "fvrp_map.svh"
module fvrp_ctrl_test;
    import fvrp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic fail = 1'b0, host_rd_valid = 1'b0, pready, pslverr, host_rd_invalid;
    logic [7:0]  paddr = 8'h00;
    logic [17:0] host_rd_addr = 18'h00000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [33:0] notes[$];
    logic [33:0] nt;
    int inv_seen = 0;
    fvrp_arr_req_type arr_req;
    fvrp_arr_rsp_type arr_rsp;
    int err_total = 0;
    int comparisons = 0;
    logic [50:0] bad[9] = '{{16'h0200, 16'h0, 16'h0, 3'h1}, {16'h0203, 16'h0, 16'h0, 3'h0},
        {16'h0300, 16'h4, 16'h1, 3'h2}, {16'h0301, 16'hfff8, 16'h2, 3'h2}, {16'h0300, 16'h0, 16'h1, 3'h1},
        {16'h0400, 16'h0, 16'h0, 3'h0}, {16'h0400, 16'h8, 16'h0, 3'h1}, {16'h0600, 16'h0, 16'h0, 3'h4},
        {16'h0602, 16'h0, 16'h0, 3'h5}};
    always #10 pclk = ~pclk;
    fvrp_ctrl #(.BLOCK_PHRASES(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .arr_req(arr_req), .arr_rsp(arr_rsp),
        .host_rd_valid(host_rd_valid), .host_rd_addr(host_rd_addr), .host_rd_invalid(host_rd_invalid));
    fvrp_array_model i_arr (.pclk(pclk), .presetn(presetn), .req(arr_req), .fail(fail), .rsp(arr_rsp));
    task automatic finish_test();
        $display("counts: %0d mismatches in %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c, input logic [31:0] e);
        if (!w) notes.push_back({a > `FVRP_OFF_FAULT, c, e});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 32'h0);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 1'b1, e);
    endtask
    task automatic slot(input logic [2:0] i, input logic [15:0] d);
        wr(`FVRP_OFF_INDEX, {29'h0, i});
        wr(`FVRP_OFF_PARAM, {16'h0, d});
    endtask
    task automatic host_read(input logic [17:0] a);
        repeat (7) @(posedge pclk);
        host_rd_valid <= 1'b1;
        host_rd_addr  <= a;
        @(posedge pclk);
        host_rd_valid <= 1'b0;
    endtask
    task automatic launch(input logic [2:0] ix, input logic busy, input logic [31:0] st);
        wr(`FVRP_OFF_INDEX, {29'h0, ix});
        wr(`FVRP_OFF_STAT, 32'h80);
        apb(1'b0, `FVRP_OFF_STAT, 32'h0, busy, 32'h0);
        repeat (100) if (rd[7] !== 1'b1) apb(1'b0, `FVRP_OFF_STAT, 32'h0, 1'b0, 32'h0);
        rdc(`FVRP_OFF_STAT, st);
        wr(`FVRP_OFF_STAT, 32'h30);
    endtask
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite) begin
            nt = notes.pop_front();
            if (nt[32]) cmp("prdata", nt[31:0], prdata);
            cmp("pslverr", {31'h0, nt[33]}, {31'h0, pslverr});
        end
    always @(posedge pclk)
        if (host_rd_invalid === 1'b1) inv_seen++;
    initial begin
        #1000000;
        err_total++;
        finish_test();
    end
    initial begin
        void'($urandom(83));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(`FVRP_OFF_STAT, 32'h80);
        rdc(8'h40, 32'h0);
        slot(3'h0, 16'h0200);
        fork
            launch(3'h0, 1'b1, 32'h80);
            host_read(18'h00000);
        join
        rdc(`FVRP_OFF_FAULT, 32'h3);
        fail <= 1'b1;
        launch(3'h0, 1'b1, 32'h83);
        fail <= 1'b0;
        $display("block verify test done");
        foreach (bad[i]) begin
            slot(3'h0, bad[i][50:35]);
            slot(3'h1, bad[i][34:19]);
            slot(3'h2, bad[i][18:3]);
            launch(bad[i][2:0], 1'b0, 32'ha0);
        end
        wr(`FVRP_OFF_CFG, 32'h1);
        slot(3'h1, 16'h0);
        slot(3'h0, 16'h0400);
        launch(3'h1, 1'b0, 32'ha0);
        wr(`FVRP_OFF_CFG, 32'h0);
        $display("launch error test done");
        slot(3'h1, 16'h3);
        fork
            launch(3'h1, 1'b1, 32'h80);
            host_read(18'h10000);
        join
        for (int i = 2; i < 6; i++) begin
            wr(`FVRP_OFF_INDEX, 32'(i));
            rdc(`FVRP_OFF_PARAM, 32'(i - 1) * 32'h1111);
        end
        $display("one-time read test done");
        slot(3'h0, 16'h0600);
        slot(3'h1, 16'h0010);
        for (int i = 2; i < 6; i++) slot(3'(i), 16'($urandom()));
        launch(3'h5, 1'b1, 32'h80);
        slot(3'h0, 16'h0300);
        slot(3'h2, 16'h1);
        launch(3'h2, 1'b1, 32'h82);
        wr(`FVRP_OFF_PROT, 32'h8000_0000);
        slot(3'h0, 16'h0600);
        slot(3'h1, 16'h0018);
        launch(3'h5, 1'b0, 32'h90);
        wr(`FVRP_OFF_PROT, 32'h0);
        fail <= 1'b1;
        launch(3'h5, 1'b1, 32'h83);
        $display("program test done");
        cmp("host_rd_invalid", 32'h2, 32'(inv_seen));
        finish_test();
    end
endmodule // fvrp_ctrl_test
